// file: hw/clr_reg.sv
`timescale 1ns/1ps

// register with clock enable, async clear and sync reset
module clr_reg #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    input  wire logic         aclr,
    input  wire logic         ena,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    always_comb
    begin
        if (sys_rst)
            q_nxt = '0;
        else if (ena)
            q_nxt = d;
        else
            q_nxt = q_r;
    end

    always_ff @(posedge clk_sys or posedge aclr)
    begin
        if (aclr)
            q_r <= '0;
        else
            q_r <= q_nxt;
    end

    assign q = q_r;

endmodule : clr_reg

// file: hw/mult_lane.sv
`timescale 1ns/1ps

// one multiplier lane; each operand signed or unsigned, full precision
module mult_lane #(
    parameter int W = 9
) (
    input  wire logic [W-1:0]   a,
    input  wire logic [W-1:0]   b,
    input  wire logic           sa,
    input  wire logic           sb,
    output logic      [2*W-1:0] p
);

    logic signed [W:0]     a_ext;
    logic signed [W:0]     b_ext;
    logic signed [2*W+1:0] full;

    // one extra bit turns either operand into signed or zero-extended
    always_comb
    begin
        a_ext = $signed({sa & a[W-1], a});
        b_ext = $signed({sb & b[W-1], b});
        full  = a_ext * b_ext;
        p     = full[2*W-1:0];
    end

endmodule : mult_lane

// file: hw/mult_pkg.sv
package mult_pkg;

    // --------------------------------------------------------------
    // widths
    // --------------------------------------------------------------
    localparam int WIDE_W        = 18;
    localparam int NARROW_W      = 9;
    localparam int NARROW_LANES  = 2;
    localparam int PROD_W        = 2 * WIDE_W;
    localparam int NARROW_PROD_W = 2 * NARROW_W;

    // --------------------------------------------------------------
    // carriers
    // --------------------------------------------------------------
    typedef struct packed {
        logic [WIDE_W-1:0] a;
        logic [WIDE_W-1:0] b;
    } operand_t;

    typedef struct packed {
        logic sa;
        logic sb;
    } sign_sel_t;

    typedef struct packed {
        logic wide_mode;
        logic sign_used;
        logic sign_in_reg;
        logic data_in_reg;
        logic out_reg;
    } mult_cfg_t;

    typedef struct packed {
        logic [PROD_W-1:0] value;
        logic              is_signed;
    } result_t;

    localparam int RESULT_W = $bits(result_t);

    // result is signed when either operand is signed
    function automatic logic any_signed(input sign_sel_t s);
        return s.sa | s.sb;
    endfunction : any_signed

endpackage : mult_pkg

// file: hw/signed_embedded_multiplier.sv
`timescale 1ns/1ps

module signed_embedded_multiplier (
    input  wire logic                clk_sys,
    input  wire logic                sys_rst,
    input  wire logic                aclr,
    input  wire logic                ena,
    input  wire mult_pkg::mult_cfg_t cfg,
    input  wire mult_pkg::operand_t  ops,
    input  wire logic                signa,
    input  wire logic                signb,
    output mult_pkg::result_t        product
);

    import mult_pkg::*;

    // ------------------------------------------------------------------
    // input registers
    // ------------------------------------------------------------------
    sign_sel_t sign_raw;
    sign_sel_t sign_q;
    sign_sel_t sign_eff;
    operand_t  op_q;
    operand_t  op_eff;

    assign sign_raw = '{sa: signa, sb: signb};

    // one shared enable and clear for every register of the block
    clr_reg #(
        .W ($bits(sign_sel_t))
    ) u_sign_reg (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .aclr    (aclr),
        .ena     (ena),
        .d       (sign_raw),
        .q       (sign_q)
    );

    clr_reg #(
        .W ($bits(operand_t))
    ) u_op_reg (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .aclr    (aclr),
        .ena     (ena),
        .d       (ops),
        .q       (op_q)
    );

    // selects are used live when sign_in_reg is clear and from u_sign_reg a cycle later when set; sign_used clear forces both to 0
    always_comb
    begin
        if (!cfg.sign_used)
            sign_eff = '0;
        else if (cfg.sign_in_reg)
            sign_eff = sign_q;
        else
            sign_eff = sign_raw;
        op_eff = cfg.data_in_reg ? op_q : ops;
    end

    // ------------------------------------------------------------------
    // multiplier lanes
    // ------------------------------------------------------------------
    logic [PROD_W-1:0]        wide_p;
    logic [NARROW_PROD_W-1:0] narrow_p [NARROW_LANES];
    logic [PROD_W-1:0]        narrow_cat;
    result_t                  prod_comb;

    mult_lane #(
        .W (WIDE_W)
    ) u_wide (
        .a  (op_eff.a),
        .b  (op_eff.b),
        .sa (sign_eff.sa),
        .sb (sign_eff.sb),
        .p  (wide_p)
    );

    genvar g;
    generate
        for (g = 0; g < NARROW_LANES; g++)
        begin : g_narrow
            // both lanes take the same pair of selects
            mult_lane #(
                .W (NARROW_W)
            ) u_lane (
                .a  (op_eff.a[g*NARROW_W +: NARROW_W]),
                .b  (op_eff.b[g*NARROW_W +: NARROW_W]),
                .sa (sign_eff.sa),
                .sb (sign_eff.sb),
                .p  (narrow_p[g])
            );
            assign narrow_cat[g*NARROW_PROD_W +: NARROW_PROD_W] = narrow_p[g];
        end
    endgenerate

    always_comb
    begin
        prod_comb.value     = cfg.wide_mode ? wide_p : narrow_cat;
        prod_comb.is_signed = any_signed(sign_eff);
    end

    // ------------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------------
    result_t stage_q;
    result_t out_d;

    clr_reg #(
        .W (RESULT_W)
    ) u_stage_reg (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .aclr    (aclr),
        .ena     (ena),
        .d       (prod_comb),
        .q       (stage_q)
    );

    // optional stage adds one cycle; the port flop is always there
    assign out_d = cfg.out_reg ? stage_q : prod_comb;

    clr_reg #(
        .W (RESULT_W)
    ) u_out_reg (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .aclr    (aclr),
        .ena     (ena),
        .d       (out_d),
        .q       (product)
    );

    // ------------------------------------------------------------------
    // reference model for checks
    // ------------------------------------------------------------------
    function automatic longint ref_mul(
        input longint a,
        input longint b,
        input int     w,
        input logic   sa,
        input logic   sb
    );
        longint av;
        longint bv;
        av = a;
        bv = b;
        if (sa && a[w-1])
            av = a - (longint'(1) << w);
        if (sb && b[w-1])
            bv = b - (longint'(1) << w);
        return av * bv;
    endfunction : ref_mul

    longint            ref_w;
    longint            ref_lo;
    longint            ref_hi;
    logic [PROD_W-1:0] ref_val;

    always_comb
    begin
        ref_w  = ref_mul(longint'(op_eff.a), longint'(op_eff.b), WIDE_W,
                         sign_eff.sa, sign_eff.sb);
        ref_lo = ref_mul(longint'(op_eff.a[NARROW_W-1:0]),
                         longint'(op_eff.b[NARROW_W-1:0]), NARROW_W,
                         sign_eff.sa, sign_eff.sb);
        ref_hi = ref_mul(longint'(op_eff.a[WIDE_W-1:NARROW_W]),
                         longint'(op_eff.b[WIDE_W-1:NARROW_W]), NARROW_W,
                         sign_eff.sa, sign_eff.sb);
        if (cfg.wide_mode)
            ref_val = ref_w[PROD_W-1:0];
        else
            ref_val = {ref_hi[NARROW_PROD_W-1:0], ref_lo[NARROW_PROD_W-1:0]};
    end

    // ------------------------------------------------------------------
    // plain unsigned products, independent of the lanes
    // ------------------------------------------------------------------
    logic [PROD_W-1:0] plain_prod;
    logic [PROD_W-1:0] plain_in;

    assign plain_prod = PROD_W'(op_eff.a) * PROD_W'(op_eff.b);
    assign plain_in   = PROD_W'(ops.a) * PROD_W'(ops.b);

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst || aclr);

    sequence s_direct;
        ena && !cfg.out_reg;
    endsequence

    sequence s_staged_two;
        (ena && cfg.out_reg && $stable(cfg))[*2];
    endsequence

    sequence s_sign_path;
        ena && cfg.sign_used && cfg.sign_in_reg && !cfg.out_reg;
    endsequence

    sequence s_data_path;
        ena && cfg.wide_mode && !cfg.sign_used && cfg.data_in_reg && !cfg.out_reg;
    endsequence

    a_signed_flag: assert property (
        s_direct |=> product.is_signed == ($past(sign_eff) != '0))
        else $error("result sign flag does not follow the sign selects");

    a_unsigned_default: assert property (
        s_direct ##0 !cfg.sign_used |=> !product.is_signed)
        else $error("unused sign selects did not give unsigned result");

    a_wide_full: assert property (
        s_direct ##0 cfg.wide_mode |=> product.value == $past(ref_val))
        else $error("wide product is not the full-precision product");

    a_dual_lanes: assert property (
        s_direct ##0 !cfg.wide_mode |=> product.value == $past(ref_val))
        else $error("dual lane products are wrong");

    a_sign_capture: assert property (
        ena |=> sign_q == $past(sign_raw))
        else $error("sign input register missed a capture");

    a_runtime_sign: assert property (
        s_direct ##0 cfg.sign_used && !cfg.sign_in_reg && $changed(sign_raw)
        |=> product.is_signed == ($past(sign_raw) != '0))
        else $error("run-time sign change was not applied");

    a_ena_hold: assert property (
        !ena |=> $stable(product) && $stable(stage_q) && $stable(sign_q))
        else $error("registers moved with clock enable low");

    a_out_latency: assert property (
        s_staged_two |=> product == $past(prod_comb, 2))
        else $error("output register stage latency is wrong");

    a_clear_zero: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        aclr |-> product == '0 && stage_q == '0 && sign_q == '0 && op_q == '0)
        else $error("asynchronous clear left a register non-zero");

    a_sign_delay: assert property (
        ena ##1 s_sign_path |=> product.is_signed == ($past(sign_raw, 2) != '0))
        else $error("registered sign selects took effect at the wrong cycle");

    a_plain_unsigned: assert property (
        s_direct ##0 cfg.wide_mode && !any_signed(sign_eff)
        |=> product.value == $past(plain_prod))
        else $error("unsigned wide product lost precision");

    a_both_negative: assert property (
        s_direct ##0 cfg.wide_mode && sign_eff.sa && sign_eff.sb
        && op_eff.a[WIDE_W-1] && op_eff.b[WIDE_W-1]
        |=> !product.value[PROD_W-1])
        else $error("product of two negative operands came out negative");

    a_data_delay: assert property (
        ena ##1 s_data_path |=> product.value == $past(plain_in, 2))
        else $error("registered operands took effect at the wrong cycle");

    a_op_capture: assert property (
        ena |=> op_q == $past(ops))
        else $error("operand input register missed a capture");

    a_op_hold: assert property (
        !ena |=> $stable(op_q))
        else $error("operand input register moved with clock enable low");

    a_stage_capture: assert property (
        ena |=> stage_q == $past(prod_comb))
        else $error("output stage register missed a capture");

    a_out_direct: assert property (
        s_direct |=> product == $past(prod_comb))
        else $error("unstaged output did not follow the lanes");

    a_reset_zero: assert property (
        @(posedge clk_sys) disable iff (aclr)
        sys_rst |=> product == '0 && stage_q == '0 && sign_q == '0 && op_q == '0)
        else $error("synchronous reset left a register non-zero");

endmodule : signed_embedded_multiplier

// file: tb/fabric_acc.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// user-side accumulator behind the multiplier
// ----------------------------------------------------------------
module fabric_acc (
    input  wire logic              clk_sys,
    input  wire logic              clr,
    input  wire logic              take,
    input  wire mult_pkg::result_t product,
    output logic [47:0]            acc_r
);
    import mult_pkg::*;

    logic [47:0] acc_nxt;

    always_comb
    begin
        acc_nxt = acc_r;
        if (clr)
            acc_nxt = 48'h0000_0000_0000;
        else if (take)
            acc_nxt = acc_r + {12'h000, product.value};
    end

    always_ff @(posedge clk_sys)
        acc_r <= acc_nxt;

endmodule : fabric_acc

// file: tb/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    import mult_pkg::*;

    // ------------------------------------------------------------
    // stimulus and observation
    // ------------------------------------------------------------
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic        aclr    = 1'b0;
    logic        ena     = 1'b1;
    mult_cfg_t   cfg     = '0;
    operand_t    ops     = '0;
    logic        signa   = 1'b0;
    logic        signb   = 1'b0;
    logic        take    = 1'b0;
    logic        acc_clr = 1'b1;
    result_t     product;
    logic [47:0] acc;
    int          fail_count = 0;
    int          num_checks = 0;

    always #50 clk_sys = ~clk_sys;

    signed_embedded_multiplier dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .aclr(aclr),
        .ena(ena), .cfg(cfg), .ops(ops), .signa(signa), .signb(signb), .product(product));

    fabric_acc user_u (.clk_sys(clk_sys), .clr(acc_clr), .take(take), .product(product),
        .acc_r(acc));

    // ------------------------------------------------------------
    // reference and helpers
    // ------------------------------------------------------------
    function automatic logic [35:0] mref(input logic [17:0] a, input logic [17:0] b,
                                         input int w, input logic sa, input logic sb);
        longint ea;
        longint eb;
        longint p;
        ea = longint'(a) & ((longint'(1) << w) - 1);
        eb = longint'(b) & ((longint'(1) << w) - 1);
        if (sa && ea[w-1]) ea = ea - (longint'(1) << w);
        if (sb && eb[w-1]) eb = eb - (longint'(1) << w);
        p = ea * eb;
        return p[35:0] & ((36'h0_0000_0001 << (2 * w)) - 36'h0_0000_0001);
    endfunction : mref

    function automatic logic [35:0] expv(input mult_cfg_t c, input logic s1, input logic s2);
        logic [35:0] lo;
        logic [35:0] hi;
        logic        sa;
        logic        sb;
        sa = c.sign_used & s1;
        sb = c.sign_used & s2;
        if (c.wide_mode) return mref(ops.a, ops.b, 18, sa, sb);
        lo = mref({9'h000, ops.a[8:0]}, {9'h000, ops.b[8:0]}, 9, sa, sb);
        hi = mref({9'h000, ops.a[17:9]}, {9'h000, ops.b[17:9]}, 9, sa, sb);
        return {hi[17:0], lo[17:0]};
    endfunction : expv

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : step

    task automatic drive(input mult_cfg_t c, input logic [17:0] a, input logic [17:0] b,
                         input logic s1, input logic s2);
        cfg   = c;
        ops.a = a;
        ops.b = b;
        signa = s1;
        signb = s2;
    endtask : drive

    task automatic cmp_val(input string what, input logic [47:0] e, input logic [47:0] g);
        num_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : cmp_val

    task automatic check_out(input logic [35:0] e, input logic es);
        cmp_val("product value", {12'h000, e}, {12'h000, product.value});
        cmp_val("product sign", {47'h0, es}, {47'h0, product.is_signed});
    endtask : check_out

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_signs();
        mult_cfg_t c;
        for (int i = 0; i < 8; i++)
        begin
            c = mult_cfg_t'({i[2], 4'h8});
            drive(c, 18'h2_ff03, 18'h3_01fe, i[1], i[0]);
            step(1);
            check_out(expv(c, i[1], i[0]), i[1] | i[0]);
        end
    endtask : t_signs

    task automatic t_unused();
        mult_cfg_t c;
        c = mult_cfg_t'(5'h12);
        drive(c, 18'h3_ffff, 18'h2_0001, 1'b1, 1'b1);
        step(2);
        check_out(mref(18'h3_ffff, 18'h2_0001, 18, 1'b0, 1'b0), 1'b0);
    endtask : t_unused

    task automatic t_latency();
        mult_cfg_t c;
        int        lat;
        for (int i = 0; i < 4; i++)
        begin
            c   = mult_cfg_t'({2'h3, i[1], i[1], i[0]});
            lat = 1 + i[1] + i[0];
            aclr = 1'b1;
            step(1);
            aclr = 1'b0;
            drive(c, 18'h2_4007, 18'h3_8005, 1'b1, 1'b0);
            if (lat > 1)
            begin
                step(lat - 1);
                check_out(36'h0_0000_0000, 1'b0);
            end
            step(1);
            check_out(expv(c, 1'b1, 1'b0), 1'b1);
        end
    endtask : t_latency

    task automatic t_runtime();
        for (int i = 0; i < 5; i++)
        begin
            drive(mult_cfg_t'(5'h08), i[0] ? 18'h1_fe81 : 18'h1_ff80, 18'h0_01ff,
                  i[1], i[0]);
            step(1);
            check_out(expv(cfg, i[1], i[0]), i[1] | i[0]);
        end
    endtask : t_runtime

    task automatic t_sign_reg();
        mult_cfg_t c;
        c = mult_cfg_t'(5'h0c);
        drive(c, 18'h3_c1f0, 18'h0_80f1, 1'b0, 1'b0);
        step(2);
        signa = 1'b1;
        step(1);
        check_out(expv(c, 1'b0, 1'b0), 1'b0);
        step(1);
        check_out(expv(c, 1'b1, 1'b0), 1'b1);
    endtask : t_sign_reg

    task automatic t_hold();
        logic [35:0] e;
        drive(mult_cfg_t'(5'h1b), 18'h2_0010, 18'h3_0003, 1'b1, 1'b1);
        step(3);
        e = expv(cfg, 1'b1, 1'b1);
        ena = 1'b0;
        drive(cfg, 18'h0_0011, 18'h0_0022, 1'b0, 1'b0);
        step(4);
        check_out(e, 1'b1);
        ena = 1'b1;
        step(3);
        check_out(expv(cfg, 1'b0, 1'b0), 1'b0);
    endtask : t_hold

    task automatic t_clear();
        drive(mult_cfg_t'(5'h19), 18'h3_1234, 18'h2_4321, 1'b1, 1'b0);
        step(2);
        check_out(expv(cfg, 1'b1, 1'b0), 1'b1);
        aclr = 1'b1;
        #1;
        check_out(36'h0_0000_0000, 1'b0);
        step(2);
        check_out(36'h0_0000_0000, 1'b0);
        aclr = 1'b0;
    endtask : t_clear

    task automatic t_accum();
        logic [47:0] sum;
        acc_clr = 1'b0;
        drive(mult_cfg_t'(5'h18), 18'h3_fff0, 18'h0_0100, 1'b1, 1'b0);
        sum = {12'h000, expv(cfg, 1'b1, 1'b0)};
        step(1);
        take = 1'b1;
        drive(cfg, 18'h0_0333, 18'h0_0444, 1'b0, 1'b0);
        sum = sum + {12'h000, expv(cfg, 1'b0, 1'b0)};
        step(2);
        take = 1'b0;
        cmp_val("accumulator", sum, acc);
    endtask : t_accum

    // ------------------------------------------------------------
    // run control
    // ------------------------------------------------------------
    task automatic close_out();
        if (fail_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out

    initial
    begin
        repeat (10) @(posedge clk_sys);
        #1;
        sys_rst = 1'b0;
        check_out(36'h0_0000_0000, 1'b0);
        t_signs();
        t_unused();
        t_latency();
        t_runtime();
        t_sign_reg();
        t_hold();
        t_clear();
        t_accum();
        close_out();
    end

    initial
    begin
        #200000;
        fail_count++;
        close_out();
    end

endmodule : tb_top
